// ---- qpc_map.svh ----
// Operation
// R1 - Position count is one sixteen bit register
// R2 - Phase mode compares A and B phases to count up or down
// R3 - Phase mode exists only on channels one and two
// R4 - Phase mode ignores prescale select and edge select fields
// R5 - Clear source, I/O control, interrupt enables, general registers stay active
// R6 - Overflow while counting up sets the overflow flag
// R7 - Underflow while counting down sets the underflow flag
// R8 - Readable direction flag shows up or down counting
// R9 - Software writes the mode register only while the counter is stopped
// R10 - Encoder A phase on input A, B phase on input B
// R11 - Both encoder inputs are synchronised and edge detected before stepping
// R12 - Counter wraps at maximum and at zero and keeps counting
`ifndef QPC_MAP_SVH
`define QPC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define QPC_OFF_CTRL 12'h000
`define QPC_OFF_MODE 12'h004
`define QPC_OFF_IOCTL 12'h008
`define QPC_OFF_IRQEN 12'h00c
`define QPC_OFF_STATUS 12'h010
`define QPC_OFF_CLEAR 12'h014
`define QPC_OFF_COUNT 12'h018
`define QPC_OFF_GRA 12'h01c
`define QPC_OFF_GRB 12'h020
`define QPC_OFF_START 12'h024

// ****************************************
// Fields and codes
// ****************************************
`define QPC_MODE_NORMAL 4'h0
`define QPC_MODE_PHASE 4'h4
`define QPC_CLR_NONE 3'h0
`define QPC_CLR_GRA 3'h1
`define QPC_CLR_GRB 3'h2
`define QPC_FLAG_GRA 0
`define QPC_FLAG_GRB 1
`define QPC_FLAG_OVF 2
`define QPC_FLAG_UNF 3
`define QPC_DIR_BIT 7
`define QPC_COUNT_MAX 16'hffff
`define QPC_COUNT_ZERO 16'h0000
`define QPC_PS_DIV4 6'h03
`define QPC_PS_DIV16 6'h0f
`define QPC_PS_DIV64 6'h3f

`endif

// ---- qpc_pkg.sv ----
`default_nettype none
package qpc_pkg;
   typedef logic [15:0] qpc_count_t;
   typedef logic [3:0] qpc_flags_t;
   typedef struct packed
   {
      logic [2:0] clear_source_select;
      logic [1:0] edge_select_field;
      logic [2:0] prescale_select;
   } qpc_ctrl_t;
endpackage
`default_nettype wire

// ---- qpc_step_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface qpc_step_if;
   logic up;
   logic dn;
   modport src (output up, output dn);
   modport snk (input up, input dn);
endinterface
`default_nettype wire

// ---- qpc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module qpc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- qpc_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module qpc_decoder (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Synchronised phases
   input wire logic a,
   input wire logic b,
   // Steps
   qpc_step_if.src step
);
   logic a_reg;
   logic b_reg;
   logic up_next;
   logic dn_next;

   // ****************************************
   // Quadrature transition table
   // ****************************************
   // A leading B counts up; a double change is a glitch and is dropped
   always_comb
   begin
      up_next = 1'b0;
      dn_next = 1'b0;
      unique case ({a_reg, b_reg, a, b})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: up_next = 1'b1; // R2
         4'b0001, 4'b0111, 4'b1110, 4'b1000: dn_next = 1'b1; // R2
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         step.up <= 1'b0;
         step.dn <= 1'b0;
      end
      else if (ce)
      begin
         a_reg <= a; // R11
         b_reg <= b;
         step.up <= up_next;
         step.dn <= dn_next;
      end
   end
endmodule
`default_nettype wire

// ---- qpc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qpc_map.svh"
module qpc_top #(
   parameter int CHANNEL = 1
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder and capture pins
   input wire logic ext_clock_in_a,
   input wire logic ext_clock_in_b,
   input wire logic cap_in_a,
   input wire logic cap_in_b,
   // Outputs
   output logic cmp_out_a,
   output logic cmp_out_b,
   output logic irq
);
   // Only channels 1 and 2 can select phase mode; the phase decoder is built on every channel
   localparam bit PHASE_OK = (CHANNEL == 1) || (CHANNEL == 2); // R3

   qpc_pkg::qpc_ctrl_t counter_control_reg;
   logic [3:0] channel_mode_reg;
   logic [1:0] io_control_reg;
   qpc_pkg::qpc_flags_t irq_enable_reg;
   qpc_pkg::qpc_flags_t flag_register;
   qpc_pkg::qpc_flags_t flag_set;
   qpc_pkg::qpc_count_t position_count;
   qpc_pkg::qpc_count_t count_next;
   qpc_pkg::qpc_count_t gra_reg;
   qpc_pkg::qpc_count_t grb_reg;
   logic run_reg;
   logic direction_flag;
   logic [5:0] ps_cnt_reg;
   logic [5:0] ps_mask;
   logic ps_tick;
   logic phase_mode;
   logic step_up;
   logic step_dn;
   logic [3:0] pins_sync;
   logic cap_a_reg;
   logic cap_b_reg;
   logic cap_a_edge;
   logic cap_b_edge;
   logic hit_a;
   logic hit_b;
   logic do_clear;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rd_data;

   qpc_step_if step_bus ();

   // ****************************************
   // Pin synchronisers and phase decoder
   // ****************************************
   qpc_sync #(
      .W(4)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({cap_in_b, cap_in_a, ext_clock_in_b, ext_clock_in_a}), // R10
      .q(pins_sync) // R11
   );

   qpc_decoder u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .a(pins_sync[0]),
      .b(pins_sync[1]),
      .step(step_bus.src)
   );

   assign phase_mode = PHASE_OK && (channel_mode_reg == `QPC_MODE_PHASE); // R3
   assign step_up = run_reg && (phase_mode ? step_bus.up : ps_tick); // R4
   assign step_dn = run_reg && phase_mode && step_bus.dn; // R2

   // ****************************************
   // Internal prescaler for normal mode
   // ****************************************
   always_comb
   begin
      unique case (counter_control_reg.prescale_select)
         3'h0: ps_mask = 6'h00;
         3'h1: ps_mask = `QPC_PS_DIV4;
         3'h2: ps_mask = `QPC_PS_DIV16;
         default: ps_mask = `QPC_PS_DIV64;
      endcase
   end
   assign ps_tick = ((ps_cnt_reg & ps_mask) == 6'h00);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ps_cnt_reg <= 6'h00;
      else if (ce)
         ps_cnt_reg <= run_reg ? ps_cnt_reg + 6'h01 : 6'h00;
   end

   // ****************************************
   // Capture edges
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_a_reg <= 1'b0;
         cap_b_reg <= 1'b0;
      end
      else if (ce)
      begin
         cap_a_reg <= pins_sync[2];
         cap_b_reg <= pins_sync[3];
      end
   end
   assign cap_a_edge = io_control_reg[0] && pins_sync[2] && !cap_a_reg;
   assign cap_b_edge = io_control_reg[1] && pins_sync[3] && !cap_b_reg;

   // ****************************************
   // Counter next value and compare
   // ****************************************
   always_comb
   begin
      count_next = position_count;
      if (step_up)
         count_next = position_count + 16'h0001; // R12
      else if (step_dn)
         count_next = position_count - 16'h0001; // R12
   end

   // Compare counts only on the step that reaches the value
   assign hit_a = (io_control_reg[0] ? cap_a_edge
                  : ((step_up || step_dn) && count_next == gra_reg)); // R5
   assign hit_b = (io_control_reg[1] ? cap_b_edge
                  : ((step_up || step_dn) && count_next == grb_reg)); // R5
   assign do_clear =
      (counter_control_reg.clear_source_select == `QPC_CLR_GRA && hit_a) ||
      (counter_control_reg.clear_source_select == `QPC_CLR_GRB && hit_b); // R5

   // ****************************************
   // APB decode
   // ****************************************
   assign rd_en = psel && penable && !pwrite && !pready;
   assign wr_en = psel && penable && pwrite && pready;

   always_comb
   begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr)
         `QPC_OFF_CTRL: rd_data[7:0] = counter_control_reg;
         `QPC_OFF_MODE: rd_data[3:0] = channel_mode_reg;
         `QPC_OFF_IOCTL: rd_data[1:0] = io_control_reg;
         `QPC_OFF_IRQEN: rd_data[3:0] = irq_enable_reg;
         `QPC_OFF_STATUS:
         begin
            rd_data[3:0] = flag_register;
            rd_data[`QPC_DIR_BIT] = direction_flag; // R8
         end
         `QPC_OFF_CLEAR: rd_data = 32'h0000_0000;
         `QPC_OFF_COUNT: rd_data[15:0] = position_count; // R1
         `QPC_OFF_GRA: rd_data[15:0] = gra_reg;
         `QPC_OFF_GRB: rd_data[15:0] = grb_reg;
         `QPC_OFF_START: rd_data[0] = run_reg;
         default: addr_ok = 1'b0;
      endcase
   end

   // One wait state: pready rises the cycle after the access phase opens
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         if (rd_en)
            prdata <= rd_data;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         counter_control_reg <= '0;
         channel_mode_reg <= `QPC_MODE_NORMAL;
         io_control_reg <= 2'b00;
         irq_enable_reg <= 4'h0;
         run_reg <= 1'b0;
      end
      else if (ce && wr_en)
      begin
         unique case (paddr)
            `QPC_OFF_CTRL: counter_control_reg <= pwdata[7:0];
            `QPC_OFF_MODE: channel_mode_reg <= pwdata[3:0];
            `QPC_OFF_IOCTL: io_control_reg <= pwdata[1:0];
            `QPC_OFF_IRQEN: irq_enable_reg <= pwdata[3:0]; // R5
            `QPC_OFF_START: run_reg <= pwdata[0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Position counter and general registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         position_count <= `QPC_COUNT_ZERO;
      else if (ce)
      begin
         // Software write wins over a step in the same cycle
         if (wr_en && paddr == `QPC_OFF_COUNT)
            position_count <= pwdata[15:0];
         else if (do_clear)
            position_count <= `QPC_COUNT_ZERO;
         else
            position_count <= count_next; // R1
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gra_reg <= `QPC_COUNT_MAX;
         grb_reg <= `QPC_COUNT_MAX;
      end
      else if (ce)
      begin
         if (cap_a_edge)
            gra_reg <= position_count; // R5
         else if (wr_en && paddr == `QPC_OFF_GRA)
            gra_reg <= pwdata[15:0];
         if (cap_b_edge)
            grb_reg <= position_count; // R5
         else if (wr_en && paddr == `QPC_OFF_GRB)
            grb_reg <= pwdata[15:0];
      end
   end

   // ****************************************
   // Direction and compare outputs
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         direction_flag <= 1'b1;
      else if (ce)
      begin
         if (step_dn)
            direction_flag <= 1'b0; // R8
         else if (step_up)
            direction_flag <= 1'b1; // R8
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_out_a <= 1'b0;
         cmp_out_b <= 1'b0;
      end
      else if (ce)
      begin
         if (hit_a && !io_control_reg[0])
            cmp_out_a <= !cmp_out_a;
         if (hit_b && !io_control_reg[1])
            cmp_out_b <= !cmp_out_b;
      end
   end

   // ****************************************
   // Status flags and interrupt
   // ****************************************
   always_comb
   begin
      flag_set = 4'h0;
      flag_set[`QPC_FLAG_GRA] = hit_a;
      flag_set[`QPC_FLAG_GRB] = hit_b;
      flag_set[`QPC_FLAG_OVF] = step_up && position_count == `QPC_COUNT_MAX; // R6
      flag_set[`QPC_FLAG_UNF] = step_dn && position_count == `QPC_COUNT_ZERO; // R7
   end

   // A new event outranks a clear arriving in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_register <= 4'h0;
      else if (ce)
      begin
         if (wr_en && paddr == `QPC_OFF_CLEAR)
            flag_register <= (flag_register & ~pwdata[3:0]) | flag_set; // R6 R7
         else
            flag_register <= flag_register | flag_set; // R6 R7
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else if (ce)
         irq <= |(flag_register & irq_enable_reg); // R5
   end
endmodule
`default_nettype wire

// ---- qpc_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qpc_map.svh"
module qpc_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Outputs
   input wire logic cmp_out_a,
   input wire logic irq
);
   // ****************************************
   // Bus and status checks
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable && pready;
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing one cycle after access");
   a_no_stray_ready: assert property (!(psel && penable) |=> !pready)
      else $error("pready without access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (psel && penable && !pready
      && paddr > `QPC_OFF_START |=> pslverr)
      else $error("unmapped address not refused");
   a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   a_irq_mask_off: assert property (acc && pwrite && paddr == `QPC_OFF_IRQEN
      && pwdata[3:0] == 4'h0 |=> ##1 !irq)
      else $error("irq stays high after mask");
   a_status_gaps: assert property (acc && !pwrite && paddr == `QPC_OFF_STATUS
      |-> prdata[6:4] == 3'h0 && prdata[31:8] == 24'h00_0000)
      else $error("status unused bits not zero");
   a_count_width: assert property (acc && !pwrite && paddr == `QPC_OFF_COUNT
      |-> prdata[31:16] == 16'h0000)
      else $error("count wider than sixteen bits");
   c_refused: cover property (acc && pslverr);
   c_irq: cover property ($rose(irq));
   c_match: cover property ($changed(cmp_out_a));
endmodule
bind qpc_top qpc_sva u_qpc_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_out_a(cmp_out_a),
   .irq(irq));
`default_nettype wire

// ---- qpc_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module qpc_enc_model (
   // Clock
   input wire logic pclk,
   // Encoder phases
   output logic phase_a,
   output logic phase_b
);
   // ****************************************
   // Two-phase encoder
   // ****************************************
   logic [1:0] pos_reg = 2'b00;
   // Gray order, so a legal step moves one phase only
   assign phase_a = pos_reg[1] ^ pos_reg[0];
   assign phase_b = pos_reg[1];
   task automatic steps(input int n, input bit up, input int gap);
      repeat (n)
      begin
         repeat (gap) @(posedge pclk);
         pos_reg <= up ? pos_reg + 2'b01 : pos_reg - 2'b01;
      end
   endtask
   // Deliberate fault: both phases move in one sample
   task automatic jump();
      @(posedge pclk);
      pos_reg <= pos_reg + 2'b10;
   endtask
endmodule
`default_nettype wire

// ---- quadrature_phase_counter_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "qpc_map.svh"
module quadrature_phase_counter_tb_top;
   logic pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, enc_a, enc_b, cmp_a, cmp_b, irq, ce, cap_a;
   int n_mismatch = 0;
   int comparisons = 0;
   qpc_top u_qpc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_in_a(enc_a),
      .ext_clock_in_b(enc_b), .cap_in_a(cap_a), .cap_in_b(1'b0), .cmp_out_a(cmp_a),
      .cmp_out_b(cmp_b), .irq(irq));
   qpc_enc_model u_qpc_enc_model (.pclk(pclk), .phase_a(enc_a), .phase_b(enc_b));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // A slave that never answers counts as a mismatch
      if (n >= 20)
         chk(32'h0000_0000, 32'h0000_0001);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000);
      chk(rd, e);
   endtask
   // Four edges of pipeline from pin to count, plus margin
   task automatic move(input int n, input bit up, input int gap);
      u_qpc_enc_model.steps(n, up, gap);
      repeat (6) @(posedge pclk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values();
      rdchk(`QPC_OFF_CTRL, 32'h0000_0000);
      rdchk(`QPC_OFF_STATUS, 32'h0000_0080);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0000);
      rdchk(`QPC_OFF_GRA, 32'h0000_ffff);
      apb(12'h028, 1'b0, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      $display("Test reset_values done");
   endtask
   task automatic t_up_down();
      apb(`QPC_OFF_MODE, 1'b1, 32'h0000_0004);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0001);
      move(5, 1'b1, 3);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0005);
      rdchk(`QPC_OFF_STATUS, 32'h0000_0080);
      move(7, 1'b0, 5);
      rdchk(`QPC_OFF_COUNT, 32'h0000_fffe);
      // Passing ffff also matches both general registers
      rdchk(`QPC_OFF_STATUS, 32'h0000_000b);
      chk({31'h0, cmp_b}, 32'h0000_0001);
      $display("Test up_down done");
   endtask
   task automatic t_overflow();
      move(3, 1'b1, 2);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0001);
      rdchk(`QPC_OFF_STATUS, 32'h0000_008f);
      apb(`QPC_OFF_CLEAR, 1'b1, 32'h0000_000f);
      rdchk(`QPC_OFF_STATUS, 32'h0000_0080);
      $display("Test overflow done");
   endtask
   task automatic t_glitch_fields();
      u_qpc_enc_model.jump();
      repeat (6) @(posedge pclk);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0001);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_CTRL, 1'b1, 32'h0000_001b);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0001);
      move(4, 1'b1, 1);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0005);
      $display("Test glitch_fields done");
   endtask
   task automatic t_compare_irq();
      logic c0;
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_COUNT, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_GRA, 1'b1, 32'h0000_0003);
      apb(`QPC_OFF_IRQEN, 1'b1, 32'h0000_0001);
      apb(`QPC_OFF_CTRL, 1'b1, 32'h0000_0020);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0001);
      c0 = cmp_a;
      move(3, 1'b1, 2);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0000);
      rdchk(`QPC_OFF_STATUS, 32'h0000_0081);
      chk({31'h0, cmp_a}, {31'h0, ~c0});
      chk({31'h0, irq}, 32'h0000_0001);
      apb(`QPC_OFF_IRQEN, 1'b1, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("Test compare_irq done");
   endtask
   // Clock enable low must freeze the running count
   task automatic t_normal_freeze();
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_MODE, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_CTRL, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_COUNT, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0001);
      ce <= 1'b0;
      repeat (10) @(posedge pclk);
      ce <= 1'b1;
      // Four running edges: idle, setup, access, write of the stop
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0000);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0004);
      $display("Test normal_freeze done");
   endtask
   task automatic t_capture_clear();
      logic c0;
      apb(`QPC_OFF_MODE, 1'b1, 32'h0000_0004);
      apb(`QPC_OFF_CTRL, 1'b1, 32'h0000_0040);
      apb(`QPC_OFF_COUNT, 1'b1, 32'h0000_0000);
      apb(`QPC_OFF_GRB, 1'b1, 32'h0000_0005);
      apb(`QPC_OFF_IOCTL, 1'b1, 32'h0000_0001);
      apb(`QPC_OFF_CLEAR, 1'b1, 32'h0000_000f);
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0001);
      c0 = cmp_b;
      move(2, 1'b1, 2);
      cap_a <= 1'b1;
      repeat (6) @(posedge pclk);
      rdchk(`QPC_OFF_GRA, 32'h0000_0002);
      move(3, 1'b1, 2);
      rdchk(`QPC_OFF_COUNT, 32'h0000_0000);
      rdchk(`QPC_OFF_STATUS, 32'h0000_0083);
      chk({31'h0, cmp_b}, {31'h0, ~c0});
      apb(`QPC_OFF_START, 1'b1, 32'h0000_0000);
      $display("Test capture_clear done");
   endtask
   // ****************************************
   // Run
   // ****************************************
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      presetn = 1'b0;
      ce = 1'b1;
      cap_a = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_up_down();
      t_overflow();
      t_glitch_fields();
      t_compare_irq();
      t_normal_freeze();
      t_capture_clear();
      final_report();
   end
   initial
   begin
      #200_000;
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
